// ===== dv/tb.sv
// self-checking bench for the supply monitor register block
`timescale 1ns/1ps
`default_nettype none
`include "supply_monitor_defs.svh"
module tb;
	logic aclk, aresetn;
	logic [31:0] awaddr, wdata, araddr, rdata;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, supply_below, detector_enable, irq;
	logic [3:0] wstrb, criteria_select;
	logic [1:0] bresp, rresp;
	logic [31:0] seed = 32'h36ab52a7;
	logic [31:0] v;
	logic [33:0] expq[$];
	logic [1:0] expb[$];
	int bad_count = 0;
	int cmp_count = 0;
	localparam logic [31:0] a_thr = {14'h0, `IDX_THRESHOLD, 2'h0};
	localparam logic [31:0] a_ctl = {14'h0, `IDX_CONTROL, 2'h0};
	localparam logic [31:0] a_st = {14'h0, `IDX_STATUS, 2'h0};
	localparam logic [31:0] a_clr = {14'h0, `IDX_CLEAR, 2'h0};
	localparam logic [31:0] a_en = {14'h0, `IDX_ENABLE, 2'h0};

	supply_voltage_detect_ctrl dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .supply_below(supply_below), .detector_enable(detector_enable),
		.criteria_select(criteria_select), .irq(irq));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs

	task automatic chk(input logic [33:0] got, input logic [33:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// value taken at the call; every pinned level was set at an earlier edge
	task automatic pin(input logic [33:0] got, input logic [33:0] exp);
		@(negedge aclk);
		chk(got, exp);
	endtask : pin

	task automatic results();
		$display("checks %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : results

	// handshakes judged at the falling edge, which sees what the next rising edge samples
	task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw_hs, w_hs, b_hs;
		b_hs = 1'b0;
		expb.push_back(er);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!b_hs) begin
			@(negedge aclk);
			aw_hs = awvalid && awready;
			w_hs = wvalid && wready;
			b_hs = bvalid && bready;
			@(posedge aclk);
			if (aw_hs) begin
				awvalid <= 1'b0;
			end
			if (w_hs) begin
				wvalid <= 1'b0;
			end
			if (b_hs) begin
				bready <= 1'b0;
			end
		end
	endtask : wr

	task automatic rd(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ar_hs, r_hs;
		r_hs = 1'b0;
		expq.push_back({er, d});
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!r_hs) begin
			@(negedge aclk);
			ar_hs = arvalid && arready;
			r_hs = rvalid && rready;
			@(posedge aclk);
			if (ar_hs) begin
				arvalid <= 1'b0;
			end
			if (r_hs) begin
				rready <= 1'b0;
			end
		end
	endtask : rd

	// ----------------------------------------
	// response monitor, write and read
	// ----------------------------------------
	always @(negedge aclk) begin
		if (bvalid === 1'b1 && bready === 1'b1) begin
			if (expb.size() == 0) begin
				chk(34'h0, 34'h3ffffffff);
			end else begin
				chk({32'h0, bresp}, {32'h0, expb.pop_front()});
			end
		end
		if (rvalid === 1'b1 && rready === 1'b1) begin
			if (expq.size() == 0) begin
				chk(34'h0, 34'h3ffffffff);
			end else begin
				chk({rresp, rdata}, expq.pop_front());
			end
		end
	end

	// ----------------------------------------
	// clock, watchdog, stimulus
	// ----------------------------------------
	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	// whole run is under 4000 cycles
	initial begin
		repeat (20000) @(posedge aclk);
		bad_count++;
		results();
	end

	initial begin
		aresetn = 1'b0;
		{awaddr, wdata, araddr} = '0;
		{awvalid, wvalid, bready, arvalid, rready, supply_below} = '0;
		wstrb = 4'hf;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		rd(a_thr, 32'h0, `RESP_OKAY);
		rd(a_ctl, 32'h0, `RESP_OKAY);
		rd(a_st, 32'h0, `RESP_OKAY);
		rd(a_en, 32'h0, `RESP_OKAY);
		for (int i = 0; i < 4; i++) begin
			v = xs();
			wr(a_thr, v, `RESP_OKAY);
			rd(a_thr, {28'h0, v[3:0]}, `RESP_OKAY);
			pin({30'h0, criteria_select}, {30'h0, v[3:0]});
		end
		// lane 0 strobe off: write answered, nothing stored
		@(posedge aclk);
		wstrb <= 4'h0;
		wr(a_thr, ~v, `RESP_OKAY);
		wstrb <= 4'hf;
		rd(a_thr, {28'h0, v[3:0]}, `RESP_OKAY);
		wr(a_en, 32'h7, `RESP_OKAY);
		rd(a_en, 32'h7, `RESP_OKAY);
		// supply low while the detector runs: result must not follow it yet
		supply_below <= 1'b1;
		wr(a_ctl, xs() | 32'h1, `RESP_OKAY);
		pin({33'h0, detector_enable}, 34'h1);
		repeat (20) @(posedge aclk);
		rd(a_ctl, 32'h1, `RESP_OKAY);
		pin({33'h0, irq}, 34'h0);
		repeat (1005) @(posedge aclk);
		wr(a_ctl, 32'h0, `RESP_OKAY);
		pin({33'h0, detector_enable}, 34'h0);
		rd(a_ctl, 32'h2, `RESP_OKAY);
		rd(a_st, 32'h3, `RESP_OKAY);
		pin({33'h0, irq}, 34'h1);
		@(posedge aclk);
		supply_below <= 1'b0;
		repeat (10) @(posedge aclk);
		rd(a_ctl, 32'h2, `RESP_OKAY);
		wr(a_clr, 32'h7, `RESP_OKAY);
		rd(a_st, 32'h0, `RESP_OKAY);
		pin({33'h0, irq}, 34'h0);
		// short measurement with supply normal: result captured as 0
		wr(a_ctl, 32'h1, `RESP_OKAY);
		repeat (10) @(posedge aclk);
		wr(a_ctl, 32'hfffffffc, `RESP_OKAY);
		rd(a_ctl, 32'h0, `RESP_OKAY);
		rd(a_st, 32'h5, `RESP_OKAY);
		wr(a_en, 32'h2, `RESP_OKAY);
		pin({33'h0, irq}, 34'h0);
		wr(a_en, 32'h1, `RESP_OKAY);
		pin({33'h0, irq}, 34'h1);
		// unmapped, read-only and write-only places
		rd(32'h0, 32'h0, `RESP_SLVERR);
		wr(32'h0, 32'hf, `RESP_SLVERR);
		wr(a_st, 32'h0, `RESP_OKAY);
		rd(a_st, 32'h5, `RESP_OKAY);
		rd(a_clr, 32'h0, `RESP_OKAY);
		// second reset in mid-run
		wr(a_thr, 32'h9, `RESP_OKAY);
		wr(a_ctl, 32'h1, `RESP_OKAY);
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd(a_thr, 32'h0, `RESP_OKAY);
		rd(a_ctl, 32'h0, `RESP_OKAY);
		pin({33'h0, detector_enable}, 34'h0);
		results();
	end
endmodule : tb
`default_nettype wire

// ===== verilog/sense_if.sv
// carrier between control logic and the comparator sampling stage
`timescale 1ns/1ps
`default_nettype none
interface sense_if;
	logic detector_on;
	logic capture;
	logic below;
	logic result;
	modport ctrl (output detector_on, output capture, input below, input result);
	modport sample (input detector_on, input capture, output below, output result);
endinterface : sense_if
`default_nettype wire

// ===== verilog/supply_monitor_defs.svh
// offsets, field positions, reset values and timing counts of the supply monitor
// Function
// - a four-bit read/write criteria select register picks the threshold and resets to zero.
// - bit 0 of the control register is the read/write detector-on bit and resets to zero.
// - while detector-on is 1 the detector is powered and compares supply against threshold.
// - the 1-to-0 change of detector-on loads the comparison outcome into the result latch.
// - bit 1 of the control register is the read-only result, 1 meaning supply below threshold.
// - the result latch resets to 0.
// - the two upper bits of the control register read as 0 and ignore writes.
`ifndef SUPPLY_MONITOR_DEFS_SVH
`define SUPPLY_MONITOR_DEFS_SVH

// register indices, byte address is four times the index
`define IDX_THRESHOLD 16'hff04
`define IDX_CONTROL 16'hff05
`define IDX_STATUS 16'hff08
`define IDX_CLEAR 16'hff09
`define IDX_ENABLE 16'hff0a

// control register fields
`define CTRL_ON_BIT 0
`define CTRL_RESULT_BIT 1

// reset values
`define THRESHOLD_RESET 4'h0
`define CTRL_ON_RESET 1'b0
`define RESULT_RESET 1'b0
`define EVENT_RESET 3'h0

// event bits of status, clear and enable
`define EV_CAPTURE 0
`define EV_LOW 1
`define EV_SHORT 2
`define EV_W 3

// timing
`define CLK_PERIOD_NS 100
`define MIN_ON_US 100
`define MIN_ON_CYCLES ((`MIN_ON_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ON_CNT_W 10

// bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ===== verilog/supply_monitor_pkg.sv
// shared types of the supply monitor
`default_nettype none
package supply_monitor_pkg;
	typedef enum logic [2:0] {
		st_off = 3'h1,
		st_settling = 3'h2,
		st_stable = 3'h4
	} det_state_t;
	typedef logic [3:0] nibble_t;
	typedef logic [2:0] event_t;
endpackage : supply_monitor_pkg
`default_nettype wire

// ===== verilog/supply_sample.sv
// comparator synchroniser and result latch
`timescale 1ns/1ps
`default_nettype none
`include "supply_monitor_defs.svh"
module supply_sample (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic supply_below,
	sense_if.sample port
);
	logic [2:0] sync;
	logic below;
	logic result;

	// ----------------------------------------
	// synchroniser
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync <= 3'h0;
		end else begin
			sync <= {sync[1:0], supply_below};
		end
	end

	// comparator output is meaningless while unpowered, so only track it when on
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			below <= 1'b0;
		end else if (port.detector_on && (sync[1] == sync[2])) begin
			below <= sync[2];
		end
	end

	// ----------------------------------------
	// result latch
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			result <= `RESULT_RESET;
		end else if (port.capture) begin
			result <= below;
		end
	end

	assign port.below = below;
	assign port.result = result;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence cap_taken;
		port.capture ##0 port.detector_on;
	endsequence

	chk_capture_load: assert property (@(posedge aclk) disable iff (!aresetn)
		cap_taken |=> (result == $past(below)))
		else $error("result not loaded at detector switch-off");

	chk_result_reset: assert property (@(posedge aclk) disable iff (1'b0)
		!aresetn |=> !result)
		else $error("result not cleared by reset");

	chk_result_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		!port.capture |=> $stable(result))
		else $error("result changed outside a switch-off");
endmodule : supply_sample
`default_nettype wire

// ===== verilog/supply_voltage_detect_ctrl.sv
// supply monitor control, result and interrupt registers on an axi4-lite slave
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "supply_monitor_defs.svh"
module supply_voltage_detect_ctrl (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [31:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [31:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic supply_below,
	output logic detector_enable,
	output logic [3:0] criteria_select,
	output logic irq
);
	// ----------------------------------------
	// declarations
	// ----------------------------------------
	logic aw_held;
	logic w_held;
	logic [31:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic do_write;
	logic wr_lane;
	logic wr_threshold;
	logic wr_ctrl;
	logic wr_clear;
	logic wr_enable;
	logic detector_on;
	logic falling;
	supply_monitor_pkg::det_state_t state;
	supply_monitor_pkg::det_state_t next_state;
	logic [`ON_CNT_W-1:0] on_cnt;
	supply_monitor_pkg::event_t status;
	supply_monitor_pkg::event_t enable;
	supply_monitor_pkg::event_t events;
	supply_monitor_pkg::event_t clr_bits;
	logic [31:0] rd_word;
	logic rd_hit;

	sense_if sense ();

	// ----------------------------------------
	// address decode
	// ----------------------------------------
	function automatic logic match(input logic [31:0] addr, input logic [15:0] idx);
		match = (addr[31:2] == {14'h0, idx});
	endfunction : match

	function automatic logic mapped(input logic [31:0] addr);
		mapped = match(addr, `IDX_THRESHOLD) || match(addr, `IDX_CONTROL) ||
			match(addr, `IDX_STATUS) || match(addr, `IDX_CLEAR) ||
			match(addr, `IDX_ENABLE);
	endfunction : mapped

	// ----------------------------------------
	// write channel
	// ----------------------------------------
	// one write in flight: both channels close until the response is taken
	assign awready = !aw_held && !bvalid;
	assign wready = !w_held && !bvalid;
	assign do_write = aw_held && w_held && !bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			aw_addr <= 32'h0;
		end else if (awvalid && awready) begin
			aw_held <= 1'b1;
			aw_addr <= awaddr;
		end else if (do_write) begin
			aw_held <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held <= 1'b0;
			w_data <= 32'h0;
			w_strb <= 4'h0;
		end else if (wvalid && wready) begin
			w_held <= 1'b1;
			w_data <= wdata;
			w_strb <= wstrb;
		end else if (do_write) begin
			w_held <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp <= `RESP_OKAY;
		end else if (do_write) begin
			bvalid <= 1'b1;
			bresp <= mapped(aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	// all fields live in byte lane 0
	assign wr_lane = do_write && w_strb[0];
	assign wr_threshold = wr_lane && match(aw_addr, `IDX_THRESHOLD);
	assign wr_ctrl = wr_lane && match(aw_addr, `IDX_CONTROL);
	assign wr_clear = wr_lane && match(aw_addr, `IDX_CLEAR);
	assign wr_enable = wr_lane && match(aw_addr, `IDX_ENABLE);

	// ----------------------------------------
	// threshold and detector control
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			criteria_select <= `THRESHOLD_RESET;
		end else if (wr_threshold) begin
			criteria_select <= w_data[3:0];
		end
	end

	// only bit 0 is stored; result and upper bits of the word are dropped
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			detector_on <= `CTRL_ON_RESET;
		end else if (wr_ctrl) begin
			detector_on <= w_data[`CTRL_ON_BIT];
		end
	end

	// capture in the same edge that switches off, while the comparator is still powered
	assign falling = wr_ctrl && detector_on && !w_data[`CTRL_ON_BIT];

	assign detector_enable = detector_on;
	assign sense.detector_on = detector_on;
	assign sense.capture = falling;

	supply_sample u_sample (
		.aclk(aclk),
		.aresetn(aresetn),
		.supply_below(supply_below),
		.port(sense)
	);

	// ----------------------------------------
	// on-time tracking
	// ----------------------------------------
	always_comb begin
		next_state = state;
		case (state)
			supply_monitor_pkg::st_off: begin
				if (detector_on) begin
					next_state = supply_monitor_pkg::st_settling;
				end
			end
			supply_monitor_pkg::st_settling: begin
				if (!detector_on) begin
					next_state = supply_monitor_pkg::st_off;
				end else if (on_cnt == `ON_CNT_W'(`MIN_ON_CYCLES - 1)) begin
					next_state = supply_monitor_pkg::st_stable;
				end
			end
			supply_monitor_pkg::st_stable: begin
				if (!detector_on) begin
					next_state = supply_monitor_pkg::st_off;
				end
			end
			default: begin
				next_state = supply_monitor_pkg::st_off;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= supply_monitor_pkg::st_off;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			on_cnt <= `ON_CNT_W'(0);
		end else if (state != supply_monitor_pkg::st_settling) begin
			on_cnt <= `ON_CNT_W'(0);
		end else begin
			on_cnt <= on_cnt + `ON_CNT_W'(1);
		end
	end

	// ----------------------------------------
	// interrupts
	// ----------------------------------------
	// short flags a switch-off before the minimum on-time; the result may be unstable
	assign events[`EV_CAPTURE] = falling;
	assign events[`EV_LOW] = falling && sense.below;
	assign events[`EV_SHORT] = falling && (state != supply_monitor_pkg::st_stable);
	assign clr_bits = wr_clear ? w_data[`EV_W-1:0] : `EVENT_RESET;

	// set wins over a clear in the same cycle
	for (genvar i = 0; i < `EV_W; i++) begin : g_event
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				status[i] <= 1'b0;
			end else if (events[i]) begin
				status[i] <= 1'b1;
			end else if (clr_bits[i]) begin
				status[i] <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			enable <= `EVENT_RESET;
		end else if (wr_enable) begin
			enable <= w_data[`EV_W-1:0];
		end
	end

	assign irq = |(status & enable);

	// ----------------------------------------
	// read channel
	// ----------------------------------------
	always_comb begin
		rd_word = 32'h0;
		rd_hit = 1'b1;
		if (match(araddr, `IDX_THRESHOLD)) begin
			rd_word[3:0] = criteria_select;
		end else if (match(araddr, `IDX_CONTROL)) begin
			rd_word[`CTRL_ON_BIT] = detector_on;
			rd_word[`CTRL_RESULT_BIT] = sense.result;
		end else if (match(araddr, `IDX_STATUS)) begin
			rd_word[`EV_W-1:0] = status;
		end else if (match(araddr, `IDX_ENABLE)) begin
			rd_word[`EV_W-1:0] = enable;
		end else if (!match(araddr, `IDX_CLEAR)) begin
			rd_hit = 1'b0;
		end
	end

	assign arready = !rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata <= 32'h0;
			rresp <= `RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rdata <= rd_word;
			rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
		end else if (rready) begin
			rvalid <= 1'b0;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge aclk);
	endclocking

	default disable iff (!aresetn);

	sequence ctrl_read;
		arvalid && arready && match(araddr, `IDX_CONTROL);
	endsequence

	sequence switch_off;
		wr_ctrl && detector_on && !w_data[`CTRL_ON_BIT];
	endsequence

	sequence switch_on;
		wr_ctrl && !detector_on && w_data[`CTRL_ON_BIT];
	endsequence

	chk_threshold_write: assert property (
		wr_threshold |=> (criteria_select == $past(w_data[3:0])))
		else $error("threshold select not written");

	chk_threshold_reset: assert property (disable iff (1'b0)
		!aresetn |=> (criteria_select == `THRESHOLD_RESET))
		else $error("threshold select not cleared by reset");

	chk_on_write: assert property (
		wr_ctrl |=> (detector_on == $past(w_data[`CTRL_ON_BIT])))
		else $error("detector-on bit not written");

	chk_on_powers: assert property (
		switch_on |=> detector_enable ##1 (detector_enable &&
			state == supply_monitor_pkg::st_settling))
		else $error("detector not powered after switch-on");

	chk_off_captures: assert property (
		switch_off |=> (!detector_enable && sense.result == $past(sense.below)))
		else $error("switch-off did not load the result");

	chk_result_read: assert property (
		ctrl_read |=> (rvalid && rdata[`CTRL_RESULT_BIT] == $past(sense.result)))
		else $error("result bit read wrong");

	chk_result_ro: assert property (
		(wr_ctrl && !falling) |=> $stable(sense.result))
		else $error("write changed the result bit");

	chk_upper_zero: assert property (
		ctrl_read |=> (rdata[31:2] == 30'h0))
		else $error("upper control bits not zero");

	chk_min_on: assert property (
		$rose(state == supply_monitor_pkg::st_stable) |->
			($past(on_cnt) == `ON_CNT_W'(`MIN_ON_CYCLES - 1)))
		else $error("minimum on-time miscounted");
endmodule : supply_voltage_detect_ctrl
`default_nettype wire
